// ### inc/scp_pkg.sv
`default_nettype none
package scp_pkg;
    localparam int ADDR_W = 4;
    localparam int DATA_W = 16;
    // register map
    localparam logic [3:0] A_MSTOP = 4'h0;
    localparam logic [3:0] A_CTRL = 4'h1;
    localparam logic [3:0] A_STATUS = 4'h2;
    localparam logic [3:0] A_TXBUF = 4'h3;
    localparam logic [3:0] A_RXBUF = 4'h4;
    localparam logic [3:0] A_PORT = 4'h5;
    localparam logic [3:0] A_CRCCTL = 4'h6;
    localparam logic [3:0] A_CRCIN = 4'h7;
    localparam logic [3:0] A_CRCOUT = 4'h8;
    // control fields
    localparam int B_TE = 0;
    localparam int B_RE = 1;
    localparam int B_TIE = 2;
    localparam int B_TRANSMIT_END_IRQ_ENABLE_BIT = 3;
    localparam int B_RIE = 4;
    localparam int B_SYNC = 5;
    localparam int B_IRE = 6;
    // status fields
    localparam int B_TRANSMIT_EMPTY_FLAG = 7;
    localparam int B_RECEIVE_FULL_FLAG = 6;
    localparam int B_OVERRUN_ERROR_FLAG = 5;
    localparam int B_FER = 4;
    localparam int B_PER = 3;
    localparam int B_TEND = 2;
    localparam int B_RER = 1;
    // port register fields
    localparam int B_PDR = 0;
    localparam int B_PDDR = 1;
    // crc control fields
    localparam int B_CLR = 7;
    localparam int B_LMS = 2;
    localparam logic [7:0] CRCCTL_RMASK = 8'h07;
    localparam logic [1:0] POLY_RSV = 2'h0;
    localparam logic [1:0] POLY_8 = 2'h1;
    localparam logic [1:0] POLY_16A = 2'h2;
    localparam logic [1:0] POLY_16B = 2'h3;
    // polynomial taps, reflected and normal
    localparam logic [15:0] P8_N = 16'h0007;
    localparam logic [15:0] P8_R = 16'h00e0;
    localparam logic [15:0] P16A_N = 16'h8005;
    localparam logic [15:0] P16A_R = 16'ha001;
    localparam logic [15:0] P16B_N = 16'h1021;
    localparam logic [15:0] P16B_R = 16'h8408;
    localparam logic [7:0] STATUS_RST = 8'h84;
    localparam logic [7:0] BYTE_ZERO = 8'h00;
    localparam logic [15:0] WORD_ZERO = 16'h0000;
    localparam logic [15:0] BAUD_DIV = 16'h0008;
    localparam logic [3:0] FRAME_BITS = 4'ha;
    localparam logic [3:0] SAMPLE_MID = 4'h4;
    localparam int CHANNEL_ID = 5;
endpackage
`default_nettype wire

// ### rtl/scp_top.sv
`timescale 1ns/1ns
`default_nettype none
module scp_top
    import scp_pkg::*;
#(
    parameter int CHAN = CHANNEL_ID
) (
    input wire logic CORE_CLK,
    input wire logic RST_N,
    input wire logic [scp_pkg::ADDR_W-1:0] ADDR,
    input wire logic [scp_pkg::DATA_W-1:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    output logic [scp_pkg::DATA_W-1:0] RDATA,
    input wire logic STOP_REQ,
    input wire logic RXD,
    output logic TXD_O,
    output logic TXD_OE_N,
    output logic TXI_REQ,
    output logic RXI_REQ,
    output logic DTC_TXI,
    output logic DTC_RXI,
    input wire logic TX_ACK,
    input wire logic RX_ACK
);
    import scp_pkg::*;

    logic mstop_reg;
    logic [7:0] ctrl_reg;
    logic [7:0] status_reg;
    logic [7:0] txbuf_reg;
    logic [7:0] rxbuf_reg;
    logic [1:0] port_reg;
    logic [7:0] crcctl_reg;
    logic [7:0] crcin_reg;
    logic [15:0] crc_reg;
    logic [15:0] crc_next;
    logic [15:0] baud_cnt_reg;
    logic baud_tick;
    logic [3:0] tx_bit_reg;
    logic [9:0] tx_sh_reg;
    logic tx_line_reg;
    logic [3:0] rx_bit_reg;
    logic [3:0] rx_ph_reg;
    logic [8:0] rx_sh_reg;
    logic rx_busy_reg;
    logic rx_par_reg;
    logic halted;
    logic wr_ok;
    logic rd_ok;
    logic te;
    logic tx_load;
    logic rx_done;
    logic rx_err_any;
    logic [7:0] status_wmask;
    localparam logic [3:0] PH_LAST = 4'(BAUD_DIV - 16'h1);

    typedef enum logic [1:0] {TX_IDLE, TX_SHIFT} scp_tx_t;
    scp_tx_t tx_state_reg;

    assign halted = mstop_reg | STOP_REQ;
    assign wr_ok = WR & (~mstop_reg | (ADDR == A_MSTOP));
    assign rd_ok = RD & (~mstop_reg | (ADDR == A_MSTOP));
    assign te = ctrl_reg[B_TE];
    assign rx_err_any = status_reg[B_OVERRUN_ERROR_FLAG] | status_reg[B_FER] | status_reg[B_RER];
    assign tx_load = te & baud_tick & (tx_state_reg == TX_IDLE) & ~status_reg[B_TRANSMIT_EMPTY_FLAG]
        & ~(ctrl_reg[B_SYNC] & rx_err_any);
    assign rx_done = rx_busy_reg & (rx_bit_reg == FRAME_BITS - 4'h1) & (rx_ph_reg == SAMPLE_MID);
    assign status_wmask = WDATA[7:0];

    // module stop control
    always_ff @(posedge CORE_CLK) begin
        if (!RST_N) begin
            mstop_reg <= 1'b1;
        end else if (WR && ADDR == A_MSTOP) begin
            mstop_reg <= WDATA[0];
        end
    end

    always_ff @(posedge CORE_CLK) begin
        if (!RST_N) begin
            ctrl_reg <= BYTE_ZERO;
            port_reg <= 2'h0;
            txbuf_reg <= BYTE_ZERO;
        end else begin
            if (wr_ok && ADDR == A_CTRL) begin
                ctrl_reg <= WDATA[7:0];
            end
            if (wr_ok && ADDR == A_PORT) begin
                port_reg <= WDATA[1:0];
            end
            if (halted) begin
                txbuf_reg <= BYTE_ZERO;
            end else if (wr_ok && ADDR == A_TXBUF) begin
                txbuf_reg <= WDATA[7:0];
            end
        end
    end

    // baud divider enable
    always_ff @(posedge CORE_CLK) begin
        if (!RST_N || baud_cnt_reg == BAUD_DIV - 16'h1) begin
            baud_cnt_reg <= WORD_ZERO;
        end else begin
            baud_cnt_reg <= baud_cnt_reg + 16'h1;
        end
    end
    assign baud_tick = (baud_cnt_reg == BAUD_DIV - 16'h1);

    // transmitter
    always_ff @(posedge CORE_CLK) begin
        if (!RST_N || halted || !te) begin
            tx_state_reg <= TX_IDLE;
            tx_sh_reg <= 10'h3ff;
            tx_bit_reg <= 4'h0;
        end else begin
            case (tx_state_reg)
                TX_IDLE: begin
                    if (tx_load) begin
                        tx_sh_reg <= {1'b1, txbuf_reg, 1'b0};
                        tx_bit_reg <= 4'h0;
                        tx_state_reg <= TX_SHIFT;
                    end
                end
                TX_SHIFT: begin
                    if (baud_tick) begin
                        tx_sh_reg <= {1'b1, tx_sh_reg[9:1]};
                        if (tx_bit_reg == FRAME_BITS - 4'h1) begin
                            tx_state_reg <= TX_IDLE;
                        end else begin
                            tx_bit_reg <= tx_bit_reg + 4'h1;
                        end
                    end
                end
                default: tx_state_reg <= TX_IDLE;
            endcase
        end
    end

    // pin drive: port fallback when transmit disabled and not halted, driven high while halted
    always_ff @(posedge CORE_CLK) begin
        if (!RST_N) begin
            TXD_O <= 1'b1;
            TXD_OE_N <= 1'b1;
        end else if (halted) begin
            TXD_O <= 1'b1;
            TXD_OE_N <= 1'b0;
        end else if (!te) begin
            TXD_O <= port_reg[B_PDR];
            TXD_OE_N <= ~port_reg[B_PDDR];
        end else begin
            TXD_O <= (tx_state_reg == TX_SHIFT) ? tx_sh_reg[0] : 1'b1;
            TXD_OE_N <= 1'b0;
        end
    end

    // receiver, per-clock bit phase, continues through a break
    always_ff @(posedge CORE_CLK) begin
        if (!RST_N || halted || !ctrl_reg[B_RE]) begin
            rx_busy_reg <= 1'b0;
            rx_bit_reg <= 4'h0;
            rx_ph_reg <= 4'h0;
            rx_sh_reg <= 9'h0;
        end else if (!rx_busy_reg) begin
            if (!RXD) begin
                rx_busy_reg <= 1'b1;
                rx_bit_reg <= 4'h0;
                rx_ph_reg <= 4'h0;
            end
        end else begin
            rx_ph_reg <= (rx_ph_reg == PH_LAST) ? 4'h0 : rx_ph_reg + 4'h1;
            if (rx_ph_reg == SAMPLE_MID) begin
                rx_sh_reg <= {RXD, rx_sh_reg[8:1]};
                if (rx_bit_reg == FRAME_BITS - 4'h1) begin
                    rx_busy_reg <= 1'b0;
                end else begin
                    rx_bit_reg <= rx_bit_reg + 4'h1;
                end
            end
        end
    end

    always_ff @(posedge CORE_CLK) begin
        if (!RST_N || halted) begin
            rxbuf_reg <= BYTE_ZERO;
        end else if (rx_done && !status_reg[B_RECEIVE_FULL_FLAG]) begin
            rxbuf_reg <= rx_sh_reg[8:1];
        end
    end

    always_ff @(posedge CORE_CLK) begin
        rx_par_reg <= ^rx_sh_reg[8:1];
    end

    // status: hardware sets win over software clears
    always_ff @(posedge CORE_CLK) begin
        if (!RST_N || halted) begin
            status_reg <= STATUS_RST;
        end else begin
            if (wr_ok && ADDR == A_STATUS) begin
                status_reg <= status_reg & status_wmask;
            end
            if (TX_ACK) begin
                status_reg[B_TRANSMIT_EMPTY_FLAG] <= 1'b0;
            end
            if (wr_ok && ADDR == A_TXBUF) begin
                status_reg[B_TRANSMIT_EMPTY_FLAG] <= 1'b0;
            end
            if (RX_ACK || (rd_ok && ADDR == A_RXBUF)) begin
                status_reg[B_RECEIVE_FULL_FLAG] <= 1'b0;
            end
            if (tx_load) begin
                status_reg[B_TRANSMIT_EMPTY_FLAG] <= 1'b1;
                status_reg[B_TEND] <= 1'b0;
            end
            if (tx_state_reg == TX_SHIFT && baud_tick && tx_bit_reg == FRAME_BITS - 4'h1) begin
                status_reg[B_TEND] <= 1'b1;
            end
            if (rx_done) begin
                if (!RXD) begin
                    status_reg[B_FER] <= 1'b1;
                    status_reg[B_PER] <= ~rx_par_reg | status_reg[B_PER];
                end
                if (status_reg[B_RECEIVE_FULL_FLAG]) begin
                    status_reg[B_OVERRUN_ERROR_FLAG] <= 1'b1;
                end else if (RXD) begin
                    status_reg[B_RECEIVE_FULL_FLAG] <= 1'b1;
                end
            end
        end
    end

    // transfer requests
    always_ff @(posedge CORE_CLK) begin
        if (!RST_N) begin
            TXI_REQ <= 1'b0;
            RXI_REQ <= 1'b0;
            DTC_TXI <= 1'b0;
            DTC_RXI <= 1'b0;
        end else begin
            TXI_REQ <= ~halted & status_reg[B_TRANSMIT_EMPTY_FLAG] & te & ctrl_reg[B_TIE];
            RXI_REQ <= ~halted & status_reg[B_RECEIVE_FULL_FLAG] & ctrl_reg[B_RIE];
            DTC_TXI <= (CHAN < 5) & ~halted & status_reg[B_TRANSMIT_EMPTY_FLAG] & te & ctrl_reg[B_TIE];
            DTC_RXI <= (CHAN < 5) & ~halted & status_reg[B_RECEIVE_FULL_FLAG] & ctrl_reg[B_RIE];
        end
    end

    // crc byte engine, all eight bits per cycle
    always_comb begin
        logic [15:0] c;
        logic [15:0] tap;
        logic fb;
        c = crc_reg;
        tap = WORD_ZERO;
        fb = 1'b0;
        case (crcctl_reg[1:0])
            POLY_8: tap = crcctl_reg[B_LMS] ? P8_N : P8_R;
            POLY_16A: tap = crcctl_reg[B_LMS] ? P16A_N : P16A_R;
            POLY_16B: tap = crcctl_reg[B_LMS] ? P16B_N : P16B_R;
            default: tap = WORD_ZERO;
        endcase
        for (int i = 0; i < 8; i++) begin
            if (!crcctl_reg[B_LMS]) begin
                fb = c[0] ^ WDATA[i];
                c = {1'b0, c[15:1]} ^ (fb ? tap : WORD_ZERO);
            end else if (crcctl_reg[1:0] == POLY_8) begin
                fb = c[7] ^ WDATA[7-i];
                c = {8'h00, c[6:0], 1'b0} ^ (fb ? tap : WORD_ZERO);
            end else begin
                fb = c[15] ^ WDATA[7-i];
                c = {c[14:0], 1'b0} ^ (fb ? tap : WORD_ZERO);
            end
        end
        crc_next = (crcctl_reg[1:0] == POLY_RSV) ? crc_reg : c;
    end

    always_ff @(posedge CORE_CLK) begin
        if (!RST_N) begin
            crcctl_reg <= BYTE_ZERO;
            crcin_reg <= BYTE_ZERO;
            crc_reg <= WORD_ZERO;
        end else begin
            if (wr_ok && ADDR == A_CRCCTL) begin
                crcctl_reg <= WDATA[7:0] & CRCCTL_RMASK;
            end
            if (wr_ok && ADDR == A_CRCCTL && WDATA[B_CLR]) begin
                crc_reg <= WORD_ZERO;
            end else if (wr_ok && ADDR == A_CRCIN) begin
                crcin_reg <= WDATA[7:0];
                crc_reg <= crc_next;
            end else if (wr_ok && ADDR == A_CRCOUT) begin
                crc_reg <= WDATA;
            end
        end
    end

    // read port, data one cycle after strobe
    always_ff @(posedge CORE_CLK) begin
        if (!RST_N) begin
            RDATA <= WORD_ZERO;
        end else if (rd_ok) begin
            case (ADDR)
                A_MSTOP: RDATA <= {15'h0, mstop_reg};
                A_CTRL: RDATA <= {8'h00, ctrl_reg};
                A_STATUS: RDATA <= {8'h00, status_reg};
                A_TXBUF: RDATA <= {8'h00, txbuf_reg};
                A_RXBUF: RDATA <= {8'h00, rxbuf_reg};
                A_PORT: RDATA <= {14'h0, port_reg};
                A_CRCCTL: RDATA <= {8'h00, crcctl_reg};
                A_CRCIN: RDATA <= {8'h00, crcin_reg};
                A_CRCOUT: RDATA <= crc_reg;
                default: RDATA <= WORD_ZERO;
            endcase
        end else begin
            RDATA <= WORD_ZERO;
        end
    end
endmodule // scp_top
`default_nettype wire

// ### verif/scp_chk.sv
`timescale 1ns/1ns
`default_nettype none
module scp_chk
    import scp_pkg::*;
#(
    parameter int CHAN = 5
) (
    input wire logic CORE_CLK,
    input wire logic RST_N,
    input wire logic [scp_pkg::ADDR_W-1:0] ADDR,
    input wire logic [scp_pkg::DATA_W-1:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    input wire logic [scp_pkg::DATA_W-1:0] RDATA,
    input wire logic STOP_REQ,
    input wire logic TXD_O,
    input wire logic TXD_OE_N,
    input wire logic TXI_REQ,
    input wire logic RXI_REQ,
    input wire logic DTC_TXI,
    input wire logic DTC_RXI
);
    logic stop_reg, te_reg, pdr_reg, pddr_reg;
    logic [2:0] quiet_reg;
    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (!RST_N);
    // shadow of stop bit, transmit enable and port bits
    always_ff @(posedge CORE_CLK) begin
        if (!RST_N) begin
            stop_reg <= 1'b1;
            te_reg <= 1'b0;
            {pddr_reg, pdr_reg} <= 2'h0;
        end else if (WR && ADDR == A_MSTOP) begin
            stop_reg <= WDATA[0];
        end else if (WR && !stop_reg && ADDR == A_CTRL) begin
            te_reg <= WDATA[B_TE];
        end else if (WR && !stop_reg && ADDR == A_PORT) begin
            {pddr_reg, pdr_reg} <= {WDATA[B_PDDR], WDATA[B_PDR]};
        end
    end
    // cycles since the pin setup last changed
    always_ff @(posedge CORE_CLK) begin
        if (!RST_N || STOP_REQ || (WR && (ADDR == A_CTRL || ADDR == A_PORT || ADDR == A_MSTOP))) begin
            quiet_reg <= 3'h0;
        end else if (quiet_reg != 3'h7) begin
            quiet_reg <= quiet_reg + 3'h1;
        end
    end
    stop_refuse_a: assert property ((RD && stop_reg && ADDR != A_MSTOP) |=> RDATA == 16'h0000)
        else $error("read while halted not zero");
    rd_idle_a: assert property (!RD |=> RDATA == 16'h0000)
        else $error("read data not idle");
    port_pin_a: assert property ((quiet_reg == 3'h7 && !te_reg && !stop_reg) |->
        (TXD_OE_N == !pddr_reg && (!pddr_reg || TXD_O == pdr_reg))) else $error("pin not from port bits");
    ctl_rsv_a: assert property ((RD && ADDR == A_CRCCTL) |=> RDATA[15:3] == 13'h0000)
        else $error("crc control upper bits set");
    crc_clr_a: assert property ((WR && !stop_reg && ADDR == A_CRCCTL && WDATA[B_CLR]) ##1
        (RD && ADDR == A_CRCOUT) |=> RDATA == 16'h0000) else $error("crc result not cleared");
    crc_rw_a: assert property ((WR && !stop_reg && ADDR == A_CRCOUT) ##1
        (RD && ADDR == A_CRCOUT) |=> RDATA == $past(WDATA, 2)) else $error("crc result readback");
    crc_in_a: assert property ((WR && !stop_reg && ADDR == A_CRCIN) ##1
        (RD && ADDR == A_CRCIN) |=> RDATA == ($past(WDATA, 2) & 16'h00ff)) else $error("crc input readback");
    dtc_gate_a: assert property (CHAN >= 5 ? (!DTC_TXI && !DTC_RXI) :
        (DTC_TXI == TXI_REQ && DTC_RXI == RXI_REQ)) else $error("controller request gating");
    stop_pin_a: assert property (STOP_REQ |=> (TXD_O && !TXD_OE_N))
        else $error("pin not driven high while stopped");
endmodule // scp_chk
bind scp_top scp_chk #(.CHAN(CHAN)) u_chk (.CORE_CLK(CORE_CLK), .RST_N(RST_N), .ADDR(ADDR), .WDATA(WDATA),
    .WR(WR), .RD(RD), .RDATA(RDATA), .STOP_REQ(STOP_REQ), .TXD_O(TXD_O), .TXD_OE_N(TXD_OE_N),
    .TXI_REQ(TXI_REQ), .RXI_REQ(RXI_REQ), .DTC_TXI(DTC_TXI), .DTC_RXI(DTC_RXI));
`default_nettype wire

// ### verif/scp_remote.sv
`timescale 1ns/1ns
`default_nettype none
module scp_remote (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic send,
    input wire logic [7:0] send_byte,
    input wire logic brk,
    input wire logic txd_line,
    output logic rxd,
    output logic got,
    output logic [7:0] got_byte
);
    logic [9:0] sh_reg, rs_reg;
    logic [6:0] sc_reg, rc_reg;
    logic prev_reg;
    assign rxd = brk ? 1'b0 : sh_reg[0];
    // sender, 8n1 at 8 clocks a bit, idle high
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            sh_reg <= 10'h3ff;
            sc_reg <= 7'h00;
        end else if (send && sc_reg == 7'h00) begin
            sh_reg <= {1'b1, send_byte, 1'b0};
            sc_reg <= 7'h50;
        end else if (sc_reg != 7'h00) begin
            sc_reg <= sc_reg - 7'h01;
            if (sc_reg[2:0] == 3'h1) sh_reg <= {1'b1, sh_reg[9:1]};
        end
    end
    // receiver, mid-bit samples, frames with low stop bit dropped
    always_ff @(posedge clk) begin
        prev_reg <= txd_line;
        got <= 1'b0;
        if (!rst_n) begin
            rc_reg <= 7'h00;
        end else if (rc_reg == 7'h00) begin
            if (prev_reg && !txd_line) rc_reg <= 7'h4f;
        end else begin
            rc_reg <= rc_reg - 7'h01;
            if (rc_reg[2:0] == 3'h3) rs_reg <= {txd_line, rs_reg[9:1]};
            if (rc_reg == 7'h02) begin
                got <= rs_reg[9];
                got_byte <= rs_reg[8:1];
            end
        end
    end
endmodule // scp_remote
`default_nettype wire

// ### verif/testbench.sv
`timescale 1ns/1ns
`default_nettype none
module testbench;
    import scp_pkg::*;
    logic CORE_CLK = 0, RST_N = 0, WR = 0, RD = 0, STOP_REQ = 0, RX_ACK = 0, send = 0, brk = 0, rd_d = 0;
    logic TX_ACK = 0;
    logic [3:0] ADDR = 0;
    logic [15:0] WDATA = 0, RDATA, c, w;
    logic TXD_O, TXD_OE_N, TXI_REQ, RXI_REQ, txl, rxd, got;
    logic [7:0] got_b, sb = 0, b;
    logic [15:0] eq[$], mq[$];
    logic [7:0] tq[$];
    int error_cnt = 0, n_checks = 0;
    always #50 CORE_CLK = ~CORE_CLK;
    assign txl = TXD_OE_N ? 1'b1 : TXD_O;
    scp_top u_dut (.CORE_CLK(CORE_CLK), .RST_N(RST_N), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
        .RDATA(RDATA), .STOP_REQ(STOP_REQ), .RXD(rxd), .TXD_O(TXD_O), .TXD_OE_N(TXD_OE_N), .TXI_REQ(TXI_REQ),
        .RXI_REQ(RXI_REQ), .DTC_TXI(), .DTC_RXI(), .TX_ACK(TX_ACK), .RX_ACK(RX_ACK));
    scp_remote u_rem (.clk(CORE_CLK), .rst_n(RST_N), .send(send), .send_byte(sb), .brk(brk), .rxd(rxd),
        .txd_line(txl), .got(got), .got_byte(got_b));
    task automatic cmp(input logic [15:0] act, input logic [15:0] exp);
        n_checks++;
        if (act !== exp) begin
            error_cnt++;
            $display("Error at %0t: got %h expected %h", $time, act, exp);
        end
    endtask
    task automatic complete_run();
        if (error_cnt == 0 && n_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge CORE_CLK);
        WR <= 1'b1;
        RD <= 1'b0;
        ADDR <= a;
        WDATA <= d;
    endtask
    task automatic rd(input logic [3:0] a, input logic [15:0] e, input logic [15:0] m);
        @(posedge CORE_CLK);
        RD <= 1'b1;
        WR <= 1'b0;
        ADDR <= a;
        eq.push_back(e);
        mq.push_back(m);
    endtask
    task automatic idle(input int n);
        @(posedge CORE_CLK);
        WR <= 1'b0;
        RD <= 1'b0;
        RX_ACK <= 1'b0;
        TX_ACK <= 1'b0;
        send <= 1'b0;
        repeat (n) @(posedge CORE_CLK);
    endtask
    // bit-serial reference, md = {order, poly}
    function automatic logic [15:0] crc_upd(input logic [15:0] c, input logic [7:0] d, input logic [2:0] md);
        logic [15:0] p;
        logic fb;
        p = md[2] ? ((md[1:0] == 2'h1) ? 16'h0007 : (md[0] ? 16'h1021 : 16'h8005))
            : ((md[1:0] == 2'h1) ? 16'h00e0 : (md[0] ? 16'h8408 : 16'ha001));
        for (int i = 0; i < 8; i++) begin
            if (md[2]) begin
                fb = ((md[1:0] == 2'h1) ? c[7] : c[15]) ^ d[7 - i];
                c = {c[14:0], 1'b0} ^ (fb ? p : 16'h0000);
                if (md[1:0] == 2'h1) c[15:8] = 8'h00;
            end else begin
                fb = c[0] ^ d[i];
                c = (c >> 1) ^ (fb ? p : 16'h0000);
            end
        end
        return c;
    endfunction
    // result checker, oldest note first
    always @(posedge CORE_CLK) begin
        if (rd_d) begin
            c = mq.pop_front();
            cmp(RDATA & c, eq.pop_front() & c);
        end
        if (got) cmp({8'h00, got_b}, {8'h00, tq.pop_front()});
        rd_d <= RD;
    end
    initial begin
        repeat (5000) @(posedge CORE_CLK);
        error_cnt++;
        complete_run();
    end
    initial begin
        void'($urandom(50008));
        repeat (20) @(posedge CORE_CLK);
        RST_N <= 1'b1;
        wr(A_CRCOUT, 16'h1234);
        rd(A_CRCOUT, 16'h0000, 16'hffff);
        rd(A_MSTOP, 16'h0001, 16'h0001);
        wr(A_MSTOP, 16'h0000);
        rd(A_CRCOUT, 16'h0000, 16'hffff);
        rd(4'hf, 16'h0000, 16'hffff);
        w = 16'($urandom);
        wr(A_CRCOUT, w);
        rd(A_CRCOUT, w, 16'hffff);
        for (int m = 0; m < 8; m++) begin
            wr(A_CRCCTL, {8'h00, 1'b1, 4'hf, 3'(m)});
            rd(A_CRCOUT, 16'h0000, 16'hffff);
            rd(A_CRCCTL, {13'h0000, 3'(m)}, 16'hffff);
            if (m % 4 != 0) begin
                w = 16'h0000;
                for (int k = 0; k < 4; k++) begin
                    b = 8'($urandom);
                    wr(A_CRCIN, {8'h00, b});
                    w = crc_upd(w, b, 3'(m));
                end
                rd(A_CRCIN, {8'h00, b}, 16'hffff);
                rd(A_CRCOUT, w, 16'hffff);
                wr(A_CRCIN, {8'h00, (m > 4 && m != 5) ? w[15:8] : w[7:0]});
                if (m % 4 != 1) wr(A_CRCIN, {8'h00, m > 4 ? w[7:0] : w[15:8]});
                rd(A_CRCOUT, 16'h0000, 16'hffff);
            end
        end
        wr(A_PORT, 16'h0003);
        wr(A_CTRL, 16'h0005);
        b = 8'($urandom);
        tq.push_back(b);
        wr(A_TXBUF, {8'h00, b});
        idle(20);
        rd(A_STATUS, 16'h0080, 16'h0080);
        wr(A_TXBUF, 16'h00a5);
        b = 8'($urandom);
        tq.push_back(b);
        wr(A_TXBUF, {8'h00, b});
        rd(A_STATUS, 16'h0000, 16'h0080);
        idle(250);
        wr(A_TXBUF, 16'h005a);
        idle(30);
        wr(A_PORT, 16'h0002);
        wr(A_CTRL, 16'h0000);
        idle(100);
        cmp({15'h0000, txl}, 16'h0000);
        wr(A_PORT, 16'h0003);
        idle(10);
        cmp({15'h0000, txl}, 16'h0001);
        TX_ACK <= 1'b1;
        idle(1);
        rd(A_STATUS, 16'h0000, 16'h0080);
        wr(A_CTRL, 16'h0012);
        sb <= 8'($urandom);
        send <= 1'b1;
        idle(100);
        cmp({15'h0000, RXI_REQ}, 16'h0001);
        RX_ACK <= 1'b1;
        idle(3);
        cmp({15'h0000, RXI_REQ}, 16'h0000);
        rd(A_STATUS, 16'h0000, 16'h0040);
        b = 8'($urandom);
        sb <= b;
        send <= 1'b1;
        idle(100);
        rd(A_RXBUF, {8'h00, b}, 16'hffff);
        brk <= 1'b1;
        idle(100);
        rd(A_STATUS, 16'h0010, 16'h0010);
        wr(A_STATUS, 16'h00ef);
        idle(100);
        rd(A_STATUS, 16'h0010, 16'h0010);
        wr(A_CTRL, 16'h0000);
        brk <= 1'b0;
        idle(20);
        rd(A_STATUS, 16'h0010, 16'h0010);
        wr(A_CTRL, 16'h0021);
        wr(A_TXBUF, 16'h0055);
        idle(20);
        rd(A_STATUS, 16'h0010, 16'h0090);
        wr(A_CTRL, 16'h0000);
        idle(0);
        STOP_REQ <= 1'b1;
        idle(5);
        STOP_REQ <= 1'b0;
        rd(A_STATUS, 16'h0084, 16'h00fe);
        wr(A_CTRL, 16'h0005);
        idle(3);
        cmp({15'h0000, TXI_REQ}, 16'h0001);
        rd(A_STATUS, 16'h0080, 16'h0080);
        b = 8'($urandom);
        tq.push_back(b);
        wr(A_TXBUF, {8'h00, b});
        idle(200);
        cmp(16'(tq.size()), 16'h0000);
        complete_run();
    end
endmodule // testbench
`default_nettype wire
